// File: hub_status_pkg.sv
// Shared constants and types for the hub status-indicator block
package hub_status_pkg;

  // ----------------------------------------------------------------
  // Port counts and synchroniser depth
  // ----------------------------------------------------------------
  localparam int NUM_DS_PORTS   = 6;
  localparam int NUM_HOST_PORTS = 2;
  localparam int SYNC_STAGES    = 3;

  // ----------------------------------------------------------------
  // Indicator drive levels
  // ----------------------------------------------------------------
  localparam logic LINK_RATE_LEGACY = 1'h0;
  localparam logic LINK_RATE_GEN1   = 1'h1;
  localparam logic CHARGE_DONE      = 1'h0;
  localparam logic CHARGE_WAIT      = 1'h1;
  localparam logic HOST_RATE_GEN1   = 1'h0;
  localparam logic HOST_RATE_LEGACY = 1'h1;
  localparam logic OPEN_DRAIN_LOW   = 1'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RESET_PIN_RST    = 1'h0;
  localparam logic SUSPEND_RST      = 1'h0;
  localparam logic STRAP_RST        = 1'h0;
  localparam logic SYNC_RST         = 1'h0;

  // ----------------------------------------------------------------
  // Sideband interface mode, selected by the device-mode strap
  // ----------------------------------------------------------------
  typedef enum logic {
    SB_TARGET,
    SB_BRIDGE
  } sideband_mode_t;

  localparam sideband_mode_t SB_MODE_RST = SB_TARGET;

endpackage : hub_status_pkg

// File: pin_filter_sync.sv
// Three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_filter_sync
  import hub_status_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] pinStable
);

  // ----------------------------------------------------------------
  // Per-bit chain
  // ----------------------------------------------------------------
  // First stage feeds only the second; metastability must not spread
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage_reg;
      wire  logic             agree;

      assign agree = (stage_reg[1] == stage_reg[2]);

      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          stage_reg    <= {SYNC_STAGES{SYNC_RST}};
          pinStable[b] <= SYNC_RST;
        end else begin
          stage_reg <= {stage_reg[SYNC_STAGES-2:0], pinIn[b]};
          if (agree) begin
            pinStable[b] <= stage_reg[2];
          end
        end
      end
    end
  endgenerate

endmodule : pin_filter_sync

`default_nettype wire

// File: hub_port_status_indicators.sv
// Port status indicators, reset pin, strap latch and sideband pin steering
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Port speed indicator floats unattached, low for legacy link, high for Gen 1.
// - Charge indicator floats when disabled, low after handshake, high before it.
// - Host speed indicator floats unconnected, low for Gen 1, high for legacy.
// - Suspend indicator output follows USB 2.0 suspend; host may use it for wakeup.
// - Hub stays in reset mode while the active-low reset pin is held low.
// - Sideband two-wire interface runs as target or bridge master per mode strap.
// - Straps sampled at power-on reset and each rising edge of reset pin.
module hub_port_status_indicators
  import hub_status_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // Pins from the board
  input  wire logic                      resetPinN,
  input  wire logic                      deviceModeStrap,
  // Status from the hub core
  input  wire logic [NUM_DS_PORTS:1]     portAttached,
  input  wire logic [NUM_DS_PORTS:1]     portGen1Link,
  input  wire logic [NUM_DS_PORTS:1]     portChargeEnable,
  input  wire logic [NUM_DS_PORTS:1]     portChargeHandshake,
  input  wire logic [NUM_HOST_PORTS-1:0] hostConnected,
  input  wire logic [NUM_HOST_PORTS-1:0] hostGen1Link,
  input  wire logic                      usb2Suspended,
  // Indicator pins, three-state except the always-driven suspend flag
  output var  logic [NUM_DS_PORTS:1]     portLinkRateFlagOut,
  output var  logic [NUM_DS_PORTS:1]     portLinkRateFlagOe,
  output var  logic [NUM_DS_PORTS:1]     portChargeHandshakeFlagOut,
  output var  logic [NUM_DS_PORTS:1]     portChargeHandshakeFlagOe,
  output var  logic [NUM_HOST_PORTS-1:0] hostLinkRateFlagOut,
  output var  logic [NUM_HOST_PORTS-1:0] hostLinkRateFlagOe,
  output var  logic                      suspendWakeFlag,
  // Hub reset mode to the core
  output var  logic                      hubResetMode,
  // Sideband serial pins, open drain
  input  wire logic                      sidebandSerialClockIn,
  output var  logic                      sidebandSerialClockOut,
  output var  logic                      sidebandSerialClockOe,
  input  wire logic                      sidebandSerialLineIn,
  output var  logic                      sidebandSerialLineOut,
  output var  logic                      sidebandSerialLineOe,
  // Sideband engines
  input  wire logic                      targetClockPullLow,
  input  wire logic                      targetLinePullLow,
  input  wire logic                      bridgeClockPullLow,
  input  wire logic                      bridgeLinePullLow,
  output var  logic                      sidebandClockSync,
  output var  logic                      sidebandLineSync,
  output var  logic                      targetEnable,
  output var  logic                      bridgeEnable
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire logic [3:0] pinRaw;
  wire logic [3:0] pinStable;

  assign pinRaw = {sidebandSerialLineIn, sidebandSerialClockIn, deviceModeStrap, resetPinN};

  pin_filter_sync #(
    .WIDTH     (4)
  ) u_pin_sync (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .pinIn     (pinRaw),
    .pinStable (pinStable)
  );

  wire logic resetPinStable;
  wire logic strapStable;

  assign resetPinStable    = pinStable[0];
  assign strapStable       = pinStable[1];
  assign sidebandClockSync = pinStable[2];
  assign sidebandLineSync  = pinStable[3];

  // ----------------------------------------------------------------
  // Reset pin and strap latch
  // ----------------------------------------------------------------
  // Filtered pin resets low, so the rise after power-on reset also
  // loads the straps: one path covers both sampling moments.
  logic           resetPinPrev_reg;
  sideband_mode_t sidebandMode_reg;
  sideband_mode_t sidebandMode_next;
  wire  logic     resetPinRise;

  assign resetPinRise      = resetPinStable & ~resetPinPrev_reg;
  assign sidebandMode_next = resetPinRise
                             ? (strapStable ? SB_BRIDGE : SB_TARGET)
                             : sidebandMode_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      resetPinPrev_reg <= RESET_PIN_RST;
      sidebandMode_reg <= SB_MODE_RST;
    end else begin
      resetPinPrev_reg <= resetPinStable;
      sidebandMode_reg <= sidebandMode_next;
    end
  end

  // Reset mode holds the whole time the filtered pin stays low
  assign hubResetMode = ~resetPinPrev_reg;

  // ----------------------------------------------------------------
  // Downstream port indicators
  // ----------------------------------------------------------------
  // Indicators float while in reset mode: no link state is valid then
  genvar p;
  generate
    for (p = 1; p <= NUM_DS_PORTS; p++) begin : g_ds
      wire logic rateOe_next;
      wire logic rateOut_next;
      wire logic chargeOe_next;
      wire logic chargeOut_next;

      assign rateOe_next    = portAttached[p] & ~hubResetMode;
      assign rateOut_next   = portGen1Link[p] ? LINK_RATE_GEN1 : LINK_RATE_LEGACY;
      assign chargeOe_next  = portChargeEnable[p] & ~hubResetMode;
      assign chargeOut_next = portChargeHandshake[p] ? CHARGE_DONE : CHARGE_WAIT;

      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          portLinkRateFlagOe[p]         <= 1'h0;
          portLinkRateFlagOut[p]        <= LINK_RATE_LEGACY;
          portChargeHandshakeFlagOe[p]  <= 1'h0;
          portChargeHandshakeFlagOut[p] <= CHARGE_WAIT;
        end else begin
          portLinkRateFlagOe[p]         <= rateOe_next;
          portLinkRateFlagOut[p]        <= rateOut_next;
          portChargeHandshakeFlagOe[p]  <= chargeOe_next;
          portChargeHandshakeFlagOut[p] <= chargeOut_next;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host port indicators
  // ----------------------------------------------------------------
  // Encoding is inverted against the downstream speed indicator
  genvar h;
  generate
    for (h = 0; h < NUM_HOST_PORTS; h++) begin : g_host
      wire logic hostOe_next;
      wire logic hostOut_next;

      assign hostOe_next  = hostConnected[h] & ~hubResetMode;
      assign hostOut_next = hostGen1Link[h] ? HOST_RATE_GEN1 : HOST_RATE_LEGACY;

      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          hostLinkRateFlagOe[h]  <= 1'h0;
          hostLinkRateFlagOut[h] <= HOST_RATE_LEGACY;
        end else begin
          hostLinkRateFlagOe[h]  <= hostOe_next;
          hostLinkRateFlagOut[h] <= hostOut_next;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Suspend indicator
  // ----------------------------------------------------------------
  wire logic suspendWake_next;

  assign suspendWake_next = usb2Suspended & ~hubResetMode;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      suspendWakeFlag <= SUSPEND_RST;
    end else begin
      suspendWakeFlag <= suspendWake_next;
    end
  end

  // ----------------------------------------------------------------
  // Sideband pin steering
  // ----------------------------------------------------------------
  // Only the engine picked by the strap may pull the lines; the other
  // is held disabled so two masters never fight on the wire.
  wire logic targetSel;
  wire logic bridgeSel;
  wire logic clockPull_next;
  wire logic linePull_next;

  assign targetSel = (sidebandMode_reg == SB_TARGET) & ~hubResetMode;
  assign bridgeSel = (sidebandMode_reg == SB_BRIDGE) & ~hubResetMode;

  assign clockPull_next = (targetSel & targetClockPullLow)
                        | (bridgeSel & bridgeClockPullLow);
  assign linePull_next  = (targetSel & targetLinePullLow)
                        | (bridgeSel & bridgeLinePullLow);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sidebandSerialClockOe <= 1'h0;
      sidebandSerialLineOe  <= 1'h0;
      targetEnable          <= 1'h0;
      bridgeEnable          <= 1'h0;
    end else begin
      sidebandSerialClockOe <= clockPull_next;
      sidebandSerialLineOe  <= linePull_next;
      targetEnable          <= targetSel;
      bridgeEnable          <= bridgeSel;
    end
  end

  // Open drain: level is always low, the enable does the work
  assign sidebandSerialClockOut = OPEN_DRAIN_LOW;
  assign sidebandSerialLineOut  = OPEN_DRAIN_LOW;

endmodule : hub_port_status_indicators

`default_nettype wire

// File: hub_port_status_indicators_props.sv
// Concurrent checks on the hub status-indicator block
`timescale 1ns/1ps
`default_nettype none
module hub_status_checker
  import hub_status_pkg::*;
(
  input wire logic mclk, sys_rst, resetPinN, usb2Suspended, suspendWakeFlag, hubResetMode,
  input wire logic targetEnable, bridgeEnable, sidebandSerialLineOe,
  input wire logic targetLinePullLow, bridgeLinePullLow,
  input wire logic [NUM_DS_PORTS:1] portAttached, portGen1Link, portChargeEnable,
  input wire logic [NUM_DS_PORTS:1] portChargeHandshake, portLinkRateFlagOut, portLinkRateFlagOe,
  input wire logic [NUM_DS_PORTS:1] portChargeHandshakeFlagOut, portChargeHandshakeFlagOe,
  input wire logic [NUM_HOST_PORTS-1:0] hostConnected, hostGen1Link, hostLinkRateFlagOut,
  input wire logic [NUM_HOST_PORTS-1:0] hostLinkRateFlagOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Out of reset mode at this and the previous edge
  sequence running;
    !hubResetMode && !$past(hubResetMode);
  endsequence
  // Filter needs the pin stable a few edges, so allow six
  sequence pin_held_low;
    !resetPinN [*6];
  endsequence
  a_link_rate_drive: assert property (running |->
    portLinkRateFlagOe == $past(portAttached) && portLinkRateFlagOut == $past(portGen1Link))
    else $error("link rate indicator wrong");
  a_charge_drive: assert property (running |->
    portChargeHandshakeFlagOe == $past(portChargeEnable)
    && portChargeHandshakeFlagOut == ~$past(portChargeHandshake))
    else $error("charge indicator wrong");
  a_host_rate_drive: assert property (running |->
    hostLinkRateFlagOe == $past(hostConnected) && hostLinkRateFlagOut == ~$past(hostGen1Link))
    else $error("host rate indicator wrong");
  a_suspend_follow: assert property (running |-> suspendWakeFlag == $past(usb2Suspended))
    else $error("suspend flag wrong");
  a_reset_enter: assert property (pin_held_low |-> hubResetMode)
    else $error("reset mode not entered");
  a_reset_leave: assert property (resetPinN [*7] |-> !hubResetMode)
    else $error("reset mode not left");
  a_engine_route: assert property (running |-> !(targetEnable && bridgeEnable)
    && sidebandSerialLineOe == (targetEnable ? $past(targetLinePullLow)
    : bridgeEnable && $past(bridgeLinePullLow))) else $error("sideband routing wrong");
  a_strap_hold: assert property (running and !$past(hubResetMode, 2) |->
    $stable(bridgeEnable) && $stable(targetEnable)) else $error("mode changed in run");
  a_strap_taken: assert property ($fell(hubResetMode) |=> targetEnable != bridgeEnable)
    else $error("no mode after reset");
endmodule : hub_status_checker

bind hub_port_status_indicators hub_status_checker chk (.*);
`default_nettype wire

// File: hub_board_model.sv
// Board-side model: reset controller, pulled-up sideband wires, wake watcher
`timescale 1ns/1ps
`default_nettype none
module hub_board_model (
  input  wire logic holdReset,
  input  wire logic hostClockLow,
  input  wire logic hostLineLow,
  input  wire logic clockOe,
  input  wire logic lineOe,
  input  wire logic suspendWakeFlag,
  output var  logic resetPinN,
  output var  logic clockWire,
  output var  logic lineWire,
  output var  logic wakeSeen
);
  // Controller asserts reset by pulling the pin low
  assign resetPinN = !holdReset;
  // Pull-ups: a released wire reads high, any party pulling low wins
  assign clockWire = !(clockOe || hostClockLow);
  assign lineWire  = !(lineOe || hostLineLow);
  // Host takes the suspend flag as an out-of-band wake request
  assign wakeSeen = suspendWakeFlag;
endmodule : hub_board_model
`default_nettype wire

// File: hub_port_status_indicators_bench.sv
// Self-checking bench for the hub status-indicator block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module hub_port_status_indicators_bench import hub_status_pkg::*;;
  logic mclk = 1'h0, sys_rst = 1'h1, holdReset = 1'h0, deviceModeStrap = 1'h0, resetPinN;
  logic [NUM_DS_PORTS:1] portAttached = '0, portGen1Link = '0, portChargeEnable = '0;
  logic [NUM_DS_PORTS:1] portChargeHandshake = '0, ea, eg, ee, eh;
  logic [NUM_DS_PORTS:1] portLinkRateFlagOut, portLinkRateFlagOe;
  logic [NUM_DS_PORTS:1] portChargeHandshakeFlagOut, portChargeHandshakeFlagOe;
  logic [NUM_HOST_PORTS-1:0] hostConnected = '0, hostGen1Link = '0, hc, hg;
  logic [NUM_HOST_PORTS-1:0] hostLinkRateFlagOut, hostLinkRateFlagOe;
  logic usb2Suspended = 1'h0, hostClockLow = 1'h0, hostLineLow = 1'h0, es, etc, etl, ebc, ebl;
  logic targetClockPullLow = 1'h0, targetLinePullLow = 1'h0, mode = 1'h0;
  logic bridgeClockPullLow = 1'h0, bridgeLinePullLow = 1'h0, suspendWakeFlag, hubResetMode;
  logic sidebandSerialClockIn, sidebandSerialClockOut, sidebandSerialClockOe;
  logic sidebandSerialLineIn, sidebandSerialLineOut, sidebandSerialLineOe;
  logic sidebandClockSync, sidebandLineSync, targetEnable, bridgeEnable, wakeSeen;
  logic [31:0] r1, r2;
  int seed = 68613, errors = 0, n_checks = 0;

  hub_port_status_indicators uut (.*);
  hub_board_model partner (.holdReset(holdReset), .hostClockLow(hostClockLow),
    .hostLineLow(hostLineLow), .clockOe(sidebandSerialClockOe), .lineOe(sidebandSerialLineOe),
    .suspendWakeFlag(suspendWakeFlag), .resetPinN(resetPinN), .clockWire(sidebandSerialClockIn),
    .lineWire(sidebandSerialLineIn), .wakeSeen(wakeSeen));

  initial forever #4 mclk = ~mclk;

  function automatic logic pull_exp(input logic m, input logic t, input logic b);
    return m ? b : t;
  endfunction : pull_exp

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Bounded wait for reset mode to end, then let the mode latch land
  task automatic wait_ready();
    for (int k = 0; k < 20 && hubResetMode !== 1'h0; k++) @(negedge mclk);
    repeat (2) @(negedge mclk);
  endtask : wait_ready

  task automatic run_random(input int cycles);
    for (int i = 0; i < cycles; i++) begin
      @(posedge mclk);
      {ea, eg, ee, eh, hc, hg, es} = {portAttached, portGen1Link, portChargeEnable,
        portChargeHandshake, hostConnected, hostGen1Link, usb2Suspended};
      {etc, etl, ebc, ebl} = {targetClockPullLow, targetLinePullLow, bridgeClockPullLow,
        bridgeLinePullLow};
      r1 = $random(seed);
      r2 = $random(seed);
      if (i == 0) r1 = 32'hffffffff;
      if (i == 1) r1 = 32'h00fc0fc0;
      {portAttached, portGen1Link, portChargeEnable, portChargeHandshake} <= r1[23:0];
      {hostConnected, hostGen1Link, usb2Suspended, targetClockPullLow, targetLinePullLow,
        bridgeClockPullLow, bridgeLinePullLow} <= r2[8:0];
      @(negedge mclk);
      `CHK("link oe", ea, portLinkRateFlagOe)
      `CHK("link out", eg, portLinkRateFlagOut)
      `CHK("charge oe", ee, portChargeHandshakeFlagOe)
      `CHK("charge out", ~eh, portChargeHandshakeFlagOut)
      `CHK("host oe", hc, hostLinkRateFlagOe)
      `CHK("host out", ~hg, hostLinkRateFlagOut)
      `CHK("suspend", es, suspendWakeFlag)
      `CHK("wake seen", es, wakeSeen)
      `CHK("clock oe", pull_exp(mode, etc, ebc), sidebandSerialClockOe)
      `CHK("line oe", pull_exp(mode, etl, ebl), sidebandSerialLineOe)
    end
    $display("random test done");
  endtask : run_random

  // Long pulse latches the strap; a one-cycle glitch must change nothing
  task automatic pin_pulse(input logic strap, input int low);
    @(posedge mclk);
    deviceModeStrap <= strap;
    portAttached <= '1;
    repeat (6) @(posedge mclk);
    holdReset <= 1'h1;
    repeat (low) @(posedge mclk);
    holdReset <= 1'h0;
    if (low > 2) begin
      @(negedge mclk);
      `CHK("reset mode", 1'h1, hubResetMode)
      `CHK("floated", 6'h00, portLinkRateFlagOe)
      wait_ready();
      mode = strap;
    end else begin
      repeat (8) begin
        @(negedge mclk);
        `CHK("glitch", 1'h0, hubResetMode)
      end
    end
    `CHK("bridge", mode, bridgeEnable)
    `CHK("target", !mode, targetEnable)
    $display("pulse test done");
  endtask : pin_pulse

  // Host holds both wires low or releases them; the filtered levels must follow
  task automatic host_pull(input logic lvl);
    @(posedge mclk);
    {targetClockPullLow, targetLinePullLow, bridgeClockPullLow, bridgeLinePullLow} <= 4'h0;
    {hostClockLow, hostLineLow} <= {2{!lvl}};
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    `CHK("clock sync", lvl, sidebandClockSync)
    `CHK("line sync", lvl, sidebandLineSync)
    `CHK("clock out", 1'h0, sidebandSerialClockOut)
    `CHK("line out", 1'h0, sidebandSerialLineOut)
    $display("host pull test done");
  endtask : host_pull

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'h0;
    wait_ready();
    `CHK("power-on target", 1'h1, targetEnable)
    run_random(300);
    pin_pulse(1'h1, 10);
    run_random(300);
    pin_pulse(1'h0, 1);
    host_pull(1'h0);
    host_pull(1'h1);
    pin_pulse(1'h0, 10);
    run_random(100);
    final_report();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule : hub_port_status_indicators_bench
`default_nettype wire
